// >>> verilog/bus_fifo_defines.vh
// Purpose: Shared constants of the bus-matching FIFO.
// Assumes: Included by bus_fifo.v only.
// Notes: Depth counts 9-bit storage units.
`ifndef BUS_FIFO_DEFINES_VH
`define BUS_FIFO_DEFINES_VH
`define SYNC_W      42
`define PTR_W       6
`define CNT_W       7
`define OFS_W       6
`define BYTE_W      9
`define WORD_W      18
`define FIFO_DEPTH  7'h40
`define HALF_DEPTH  7'h20
`define PTR_ZERO    6'h00
`define PTR_ONE     6'h01
`define CNT_ZERO    7'h00
`define ONE_UNIT    2'h1
`define TWO_UNITS   2'h2
`define NO_UNITS    2'h0
`define FT_LAST     2'h2
`define FT_ZERO     2'h0
`define FT_STEP     2'h1
`define WORD_ZERO   18'h0_0000
`define ADR_OFFSETS 4'h0
`define ADR_STATUS  4'h4
`define ADR_CONFIG  4'h8
`define AE_FIELD    5:0
`define AF_FIELD    13:8
`define SEL_AE      0
`define SEL_AF      1
`define HI_BYTE     17:9
`define LO_BYTE     8:0
`define DEF_OFS0    6'h01
`define DEF_OFS1    6'h02
`define DEF_OFS2    6'h04
`define DEF_OFS3    6'h08
`define DEF_OFS4    6'h0C
`define DEF_OFS5    6'h10
`define DEF_OFS6    6'h18
`define DEF_OFS7    6'h1F
`endif

// >>> verilog/bus_fifo.v
// Purpose: Bus-matching FIFO with x9/x18 ports, flags, retransmit and Wishbone status.
// Assumes: All FIFO port pins are asynchronous to ref_clk and far slower than it; the Wishbone pins run on ref_clk.
// Notes: Port clocks and strobes are sampled and edge-detected on ref_clk.
// Notes on behaviour
// - Write and read widths are caught independently while master reset is low.
// - Clocked write stores data on write clock rise with write enable low.
// - Asynchronous write stores data on each write strobe rise; enable stays low.
// - Clocked read delivers next word on read clock rise with read enable low.
// - Asynchronous read delivers a word on each read strobe rise; enable stays low.
// - Write and read clocks may be unrelated; both ports work at once.
// - Standard mode shows the first word only after an enabled read.
// - Fall-through mode presents the first word after three read clock transitions.
// - First-word latency is fixed and short.
// - Retransmit is short, with a zero-latency option.
// - Master reset empties the buffer and reloads all configuration.
// - Partial reset empties data but keeps modes and offsets.
// - Empty, full and half-full outputs show fill level.
// - Almost flags use programmable offsets with eight default choices.
// - Almost flags update synchronously or asynchronously by configuration.
// - Offsets load serially or in parallel over the write data bus.
// - Fall-through mode uses output-valid and input-room instead of empty and full.
// - Read data bus is released while output enable is high.
// - Byte order, big or little, applies to width conversion.
// - Width selects low means 18 bits, high means 9 bits per port.
// - Fall-through select caught at master reset chooses the timing mode unless asynchronous read is selected.
// - Big-endian reads the high byte first; little-endian the low byte first.
// - Low retransmit request on read clock rise rewinds the read pointer.
`timescale 1ns/1ps
`include "bus_fifo_defines.vh"
module bus_fifo (
    input  wire        ref_clk,
    input  wire        sys_rst,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        masterReset_n,
    input  wire        partialReset_n,
    input  wire        writeClk,
    input  wire        writeEnable_n,
    input  wire        writeStrobe,
    input  wire [17:0] writeDataBus,
    input  wire        readClk,
    input  wire        readEnable_n,
    input  wire        readStrobe,
    input  wire        outputEnable_n,
    input  wire        writePortWidthSel,
    input  wire        readPortWidthSel,
    input  wire        fallThroughSelect,
    input  wire        asyncWriteSel,
    input  wire        asyncReadSel,
    input  wire        byteOrderSelect,
    input  wire        retransmitLatencySel,
    input  wire        retransmitRequest_n,
    input  wire        flagTimingSel,
    input  wire [2:0]  offsetDefaultSel,
    input  wire        offsetLoad_n,
    input  wire        serialEnable_n,
    input  wire        serialIn,
    output reg  [17:0] readDataBus,
    output reg         readDataOe,
    output reg         emptyFlag,
    output reg         fullFlag,
    output reg         outputValidFlag,
    output reg         inputRoomFlag,
    output reg         halfFullFlag,
    output reg         almostEmptyFlag,
    output reg         almostFullFlag
);

    function [`OFS_W-1:0] defOfs;
        input [2:0] s;
        begin
            case (s)
                3'h0: defOfs = `DEF_OFS0;
                3'h1: defOfs = `DEF_OFS1;
                3'h2: defOfs = `DEF_OFS2;
                3'h3: defOfs = `DEF_OFS3;
                3'h4: defOfs = `DEF_OFS4;
                3'h5: defOfs = `DEF_OFS5;
                3'h6: defOfs = `DEF_OFS6;
                default: defOfs = `DEF_OFS7;
            endcase
        end
    endfunction

    // Joins two stored units into a read word in the chosen byte order.
    function [`WORD_W-1:0] packWord;
        input [`BYTE_W-1:0] first;
        input [`BYTE_W-1:0] second;
        input               narrow;
        input               bigEnd;
        begin
            if (narrow) begin
                packWord = {{`BYTE_W{1'b0}}, first};
            end else if (bigEnd) begin
                packWord = {first, second};
            end else begin
                packWord = {second, first};
            end
        end
    endfunction

    reg  [`SYNC_W-1:0] syncA_r;
    reg  [`SYNC_W-1:0] syncB_r;
    wire               mrsN;
    wire               prsN;
    wire               wclk;
    wire               wenN;
    wire               wrS;
    wire [17:0]        dS;
    wire               rclk;
    wire               renN;
    wire               rdS;
    wire               oeN;
    wire               iwS;
    wire               owS;
    wire               fwftS;
    wire               asyWS;
    wire               asyRS;
    wire               beS;
    wire               rmS;
    wire               rtN;
    wire               pfmS;
    wire [2:0]         fselS;
    wire               ldN;
    wire               senN;
    wire               siS;

    assign {mrsN, prsN, wclk, wenN, wrS, dS, rclk, renN, rdS, oeN, iwS, owS, fwftS, asyWS, asyRS,
            beS, rmS, rtN, pfmS, fselS, ldN, senN, siS} = syncB_r;

    reg                wclkP_r;
    reg                wrP_r;
    reg                rclkP_r;
    reg                rdP_r;
    reg                w9_r;
    reg                r9_r;
    reg                fall_through_select_r;
    reg                asyW_r;
    reg                asyR_r;
    reg                be_r;
    reg                zeroRt_r;
    reg                asyFlag_r;
    reg  [`OFS_W-1:0]  aeOff_r;
    reg  [`OFS_W-1:0]  afOff_r;
    reg                ldSel_r;
    reg  [`BYTE_W-1:0] mem [0:`FIFO_DEPTH-1];
    reg  [`PTR_W-1:0]  wrPtr_r;
    reg  [`PTR_W-1:0]  rdPtr_r;
    reg  [`CNT_W-1:0]  cnt_r;
    reg  [1:0]         ftCnt_r;
    reg                valid_r;

    wire wclkRise = wclk & ~wclkP_r;
    wire rclkRise = rclk & ~rclkP_r;
    wire rclkTog  = rclk ^ rclkP_r;
    wire wEdge    = asyW_r ? (wrS & ~wrP_r) : wclkRise;
    wire rEdge    = asyR_r ? (rdS & ~rdP_r) : rclkRise;
    wire wrEvt    = wEdge & ~wenN;
    wire rdEvt    = rEdge & ~renN;

    wire [1:0]        wUnits = w9_r ? `ONE_UNIT : `TWO_UNITS;
    wire [1:0]        rUnits = r9_r ? `ONE_UNIT : `TWO_UNITS;
    wire [`CNT_W-1:0] wUnits7 = {{(`CNT_W-2){1'b0}}, wUnits};
    wire [`CNT_W-1:0] rUnits7 = {{(`CNT_W-2){1'b0}}, rUnits};
    wire              canW = (cnt_r + wUnits7) <= `FIFO_DEPTH;
    wire              avail = cnt_r >= rUnits7;
    wire              dataW = wrEvt & ldN & canW;
    wire              parLd = wrEvt & ~ldN;
    wire              serLd = wclkRise & ~senN & ~ldN;
    wire              rtNow = rclkRise & ~rtN;
    wire [`CNT_W-1:0] wrAll = {1'b0, wrPtr_r};
    wire              rtLoad = rtNow & zeroRt_r & (wrAll >= rUnits7);
    wire              popStd = ~fall_through_select_r & rdEvt & avail;
    wire              ftFirst = fall_through_select_r & ~valid_r & avail & rclkTog & (ftCnt_r == `FT_LAST);
    wire              ftNext = fall_through_select_r & valid_r & rdEvt & avail;
    wire              ftDrain = fall_through_select_r & valid_r & rdEvt & ~avail;
    wire              pop = ~rtNow & (popStd | ftFirst | ftNext);
    wire [`PTR_W-1:0] wrPtr1 = wrPtr_r + `PTR_ONE;
    wire [`PTR_W-1:0] rdPtr1 = rdPtr_r + `PTR_ONE;
    wire [`PTR_W-1:0] rUnitsP = {{(`PTR_W-2){1'b0}}, rUnits};
    wire [`PTR_W-1:0] wUnitsP = {{(`PTR_W-2){1'b0}}, wUnits};
    wire [`CNT_W-1:0] pushN = dataW ? wUnits7 : `CNT_ZERO;
    wire [`CNT_W-1:0] popN = pop ? rUnits7 : `CNT_ZERO;
    wire [`CNT_W-1:0] rtBase = rtLoad ? (wrAll - rUnits7) : wrAll;
    wire [`CNT_W-1:0] cnt_nxt = rtNow ? (rtBase + pushN) : (cnt_r + pushN - popN);
    wire [`WORD_W-1:0] headWord = packWord(mem[rdPtr_r], mem[rdPtr1], r9_r, be_r);
    wire [`WORD_W-1:0] rtWord = packWord(mem[`PTR_ZERO], mem[`PTR_ONE], r9_r, be_r);
    wire [`BYTE_W-1:0] wFirst = (w9_r | ~be_r) ? dS[`LO_BYTE] : dS[`HI_BYTE];
    wire [`BYTE_W-1:0] wSecond = be_r ? dS[`LO_BYTE] : dS[`HI_BYTE];
    wire              busWr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & (wb_adr_i == `ADR_OFFSETS);
    wire              mRst = ~mrsN;
    wire              pRst = ~prsN;
    wire              nxtValid = ftFirst | ftNext | (rtLoad & fall_through_select_r) | (valid_r & ~ftDrain & ~rtNow);

    // Every FIFO port pin passes two flip-flops before any logic looks at it; the Wishbone inputs do not.
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            syncA_r <= {`SYNC_W{1'b1}};
            syncB_r <= {`SYNC_W{1'b1}};
        end else begin
            syncA_r <= {masterReset_n, partialReset_n, writeClk, writeEnable_n, writeStrobe, writeDataBus,
                        readClk, readEnable_n, readStrobe, outputEnable_n, writePortWidthSel,
                        readPortWidthSel, fallThroughSelect, asyncWriteSel, asyncReadSel, byteOrderSelect,
                        retransmitLatencySel, retransmitRequest_n, flagTimingSel, offsetDefaultSel,
                        offsetLoad_n, serialEnable_n, serialIn};
            syncB_r <= syncA_r;
        end
    end

    // Configuration and offsets.
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            w9_r      <= 1'b0;
            r9_r      <= 1'b0;
            fall_through_select_r    <= 1'b0;
            asyW_r    <= 1'b0;
            asyR_r    <= 1'b0;
            be_r      <= 1'b0;
            zeroRt_r  <= 1'b0;
            asyFlag_r <= 1'b0;
            aeOff_r   <= `DEF_OFS0;
            afOff_r   <= `DEF_OFS0;
            ldSel_r   <= 1'b0;
        end else if (mRst) begin
            w9_r      <= iwS;
            r9_r      <= owS;
            fall_through_select_r    <= fwftS & ~asyRS;
            asyW_r    <= asyWS;
            asyR_r    <= asyRS;
            be_r      <= beS;
            zeroRt_r  <= ~rmS;
            asyFlag_r <= pfmS;
            aeOff_r   <= defOfs(fselS);
            afOff_r   <= defOfs(fselS);
            ldSel_r   <= 1'b0;
        end else if (busWr) begin
            if (wb_sel_i[`SEL_AE]) begin
                aeOff_r <= wb_dat_i[`AE_FIELD];
            end
            if (wb_sel_i[`SEL_AF]) begin
                afOff_r <= wb_dat_i[`AF_FIELD];
            end
        end else if (parLd) begin
            if (ldSel_r) begin
                afOff_r <= dS[`OFS_W-1:0];
            end else begin
                aeOff_r <= dS[`OFS_W-1:0];
            end
            ldSel_r <= ~ldSel_r;
        end else if (serLd) begin
            {afOff_r, aeOff_r} <= {afOff_r[`OFS_W-2:0], aeOff_r, siS};
        end
    end

    // Storage, pointers and the read word.
    always @(posedge ref_clk) begin
        if (dataW) begin
            mem[wrPtr_r] <= wFirst;
            if (!w9_r) begin
                mem[wrPtr1] <= wSecond;
            end
        end
    end

    always @(posedge ref_clk) begin
        wclkP_r <= wclk;
        wrP_r   <= wrS;
        rclkP_r <= rclk;
        rdP_r   <= rdS;
        if (sys_rst | mRst | pRst) begin
            wrPtr_r     <= `PTR_ZERO;
            rdPtr_r     <= `PTR_ZERO;
            cnt_r       <= `CNT_ZERO;
            ftCnt_r     <= `FT_ZERO;
            valid_r     <= 1'b0;
            readDataBus <= `WORD_ZERO;
        end else begin
            if (dataW) begin
                wrPtr_r <= wrPtr_r + wUnitsP;
            end
            if (rtNow) begin
                rdPtr_r <= rtLoad ? rUnitsP : `PTR_ZERO;
                if (rtLoad) begin
                    readDataBus <= rtWord;
                end
            end else if (pop) begin
                rdPtr_r     <= rdPtr_r + rUnitsP;
                readDataBus <= headWord;
            end
            cnt_r <= cnt_nxt;
            if (fall_through_select_r & ~valid_r & avail & ~rtNow) begin
                if (rclkTog) begin
                    ftCnt_r <= ftFirst ? `FT_ZERO : ftCnt_r + `FT_STEP;
                end
            end else begin
                ftCnt_r <= `FT_ZERO;
            end
            valid_r <= nxtValid;
        end
    end

    // Status flags, registered from the next fill level.
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            emptyFlag       <= 1'b1;
            fullFlag        <= 1'b0;
            outputValidFlag <= 1'b0;
            inputRoomFlag   <= 1'b0;
            halfFullFlag    <= 1'b0;
            almostEmptyFlag <= 1'b1;
            almostFullFlag  <= 1'b0;
            readDataOe      <= 1'b0;
        end else begin
            emptyFlag       <= ~fall_through_select_r & ((cnt_nxt < rUnits7) | mRst | pRst);
            fullFlag        <= ~fall_through_select_r & ((cnt_nxt + wUnits7) > `FIFO_DEPTH) & ~mRst & ~pRst;
            outputValidFlag <= fall_through_select_r & nxtValid & ~mRst & ~pRst;
            inputRoomFlag   <= fall_through_select_r & (((cnt_nxt + wUnits7) <= `FIFO_DEPTH) | mRst | pRst);
            halfFullFlag    <= (cnt_nxt > `HALF_DEPTH) & ~mRst & ~pRst;
            if (asyFlag_r | rclkRise | mRst | pRst) begin
                almostEmptyFlag <= (cnt_nxt <= {1'b0, aeOff_r}) | mRst | pRst;
            end
            if (asyFlag_r | wclkRise | mRst | pRst) begin
                almostFullFlag <= (cnt_nxt >= (`FIFO_DEPTH - {1'b0, afOff_r})) & ~mRst & ~pRst;
            end
            readDataOe <= ~oeN;
        end
    end

    // Wishbone classic slave: answers one cycle after the strobe.
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            case (wb_adr_i)
                `ADR_OFFSETS: wb_dat_o <= {16'h0000, 2'h0, afOff_r, 2'h0, aeOff_r};
                `ADR_STATUS:  wb_dat_o <= {18'h0_0000, inputRoomFlag, outputValidFlag, almostFullFlag,
                                           almostEmptyFlag, halfFullFlag, fullFlag, emptyFlag, cnt_r};
                `ADR_CONFIG:  wb_dat_o <= {24'h00_0000, asyFlag_r, zeroRt_r, be_r, asyR_r, asyW_r,
                                           fall_through_select_r, r9_r, w9_r};
                default:      wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

endmodule

// >>> bench/bus_fifo_chk.sv
// Purpose: Assertions on the FIFO flag and output-enable pins.
// Assumes: Bound to bus_fifo; one clock domain.
// Notes: The almost-empty check holds while flagTimingSel is high.
`timescale 1ns/1ps
module bus_fifo_chk (
    input logic ref_clk,
    input logic sys_rst,
    input logic masterReset_n,
    input logic partialReset_n,
    input logic outputEnable_n,
    input logic flagTimingSel,
    input logic readDataOe,
    input logic emptyFlag,
    input logic fullFlag,
    input logic outputValidFlag,
    input logic inputRoomFlag,
    input logic halfFullFlag,
    input logic almostEmptyFlag
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    a_empty_full: assert property (!(emptyFlag && fullFlag))
        else $error("empty and full both set");
    a_full_half: assert property (fullFlag |-> halfFullFlag)
        else $error("full without half-full");
    a_valid_mode: assert property (outputValidFlag |-> !emptyFlag && !fullFlag)
        else $error("output-valid beside standard flags");
    a_empty_almost: assert property (emptyFlag && flagTimingSel |-> almostEmptyFlag)
        else $error("empty without almost-empty");
    a_oe_on: assert property (!outputEnable_n [*5] |-> readDataOe)
        else $error("bus not driven");
    a_oe_off: assert property (outputEnable_n [*5] |-> !readDataOe)
        else $error("bus not released");
    a_master_clear: assert property (!masterReset_n [*5] |=> !fullFlag && !halfFullFlag && !outputValidFlag)
        else $error("master reset left data");
    a_partial_clear: assert property (!partialReset_n [*5] |=> (emptyFlag || inputRoomFlag) && !halfFullFlag)
        else $error("partial reset left data");
endmodule
bind bus_fifo bus_fifo_chk chk (.*);

// >>> bench/fifo_port_model.sv
// Purpose: Producer and consumer logic on the FIFO port pins.
// Assumes: ref_clk runs eight times faster than the port clocks.
// Notes: Port clocks stand still between transfers.
`timescale 1ns/1ps
module fifo_port_model (
    input  logic        ref_clk,
    input  logic        wAsync,
    input  logic        rAsync,
    input  logic [17:0] readDataBus,
    output logic        writeClk,
    output logic        writeEnable_n,
    output logic        writeStrobe,
    output logic [17:0] writeDataBus,
    output logic        readClk,
    output logic        readEnable_n,
    output logic        readStrobe,
    output logic        retransmitRequest_n
);
    logic wenIdle_n;
    logic renIdle_n;
    // Strobe ports keep their enables low for good.
    assign writeEnable_n = wAsync ? 1'b0 : wenIdle_n;
    assign readEnable_n  = rAsync ? 1'b0 : renIdle_n;
    initial begin
        {writeClk, writeStrobe, readClk, readStrobe, wenIdle_n, renIdle_n, retransmitRequest_n} = 7'b0000111;
        writeDataBus = 18'h0_0000;
    end
    task automatic waitCycles(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic push(input logic [17:0] d);
        waitCycles(1);
        writeDataBus <= d;
        wenIdle_n    <= 1'b0;
        waitCycles(3);
        if (wAsync) writeStrobe <= 1'b1;
        else writeClk <= 1'b1;
        waitCycles(4);
        writeClk     <= 1'b0;
        writeStrobe  <= 1'b0;
        wenIdle_n    <= 1'b1;
        writeDataBus <= ~d;
    endtask
    task automatic pop(output logic [17:0] q);
        waitCycles(1);
        renIdle_n <= 1'b0;
        waitCycles(3);
        if (rAsync) readStrobe <= 1'b1;
        else readClk <= 1'b1;
        waitCycles(4);
        q = readDataBus;
        readClk    <= 1'b0;
        readStrobe <= 1'b0;
        renIdle_n  <= 1'b1;
    endtask
    task automatic tick(input int n, input logic rt_n);
        waitCycles(1);
        retransmitRequest_n <= rt_n;
        for (int i = 0; i < n; i++) begin
            waitCycles(4);
            readClk <= ~readClk;
        end
        waitCycles(4);
        retransmitRequest_n <= 1'b1;
    endtask
endmodule

// >>> bench/tb_top.sv
// Purpose: Self-checking bench for the bus-matching FIFO.
// Assumes: The port model drives the write, read and retransmit pins; the bench drives resets and selects; Wishbone reaches status.
// Notes: Each test ends with one progress line.
`timescale 1ns/1ps
module tb_top;
    logic ref_clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, masterReset_n, partialReset_n;
    logic writeClk, writeEnable_n, writeStrobe, readClk, readEnable_n, readStrobe, outputEnable_n;
    logic writePortWidthSel, readPortWidthSel, fallThroughSelect, asyncWriteSel, asyncReadSel;
    logic byteOrderSelect, retransmitLatencySel, retransmitRequest_n, flagTimingSel, offsetLoad_n;
    logic serialEnable_n, serialIn, readDataOe, emptyFlag, fullFlag, outputValidFlag, inputRoomFlag;
    logic halfFullFlag, almostEmptyFlag, almostFullFlag;
    logic [3:0] wb_adr_i, wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, q32;
    logic [2:0] offsetDefaultSel;
    logic [17:0] writeDataBus, readDataBus, q, prev;
    logic [8:0] f, s;
    int n_mismatch = 0;
    int checked = 0;
    localparam logic [17:0] V = 18'h1_2345;
    localparam logic [17:0] W = 18'h2_A5C3;
    bus_fifo dut (.*);
    fifo_port_model pm (.wAsync(asyncWriteSel), .rAsync(asyncReadSel), .*);
    always #20 ref_clk = ~ref_clk;
    task automatic wbXfer(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
        int t;
        t = 0;
        @(posedge ref_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, a, 4'hF, d};
        do begin
            @(posedge ref_clk);
            t++;
        end while (wb_ack_o !== 1'b1 && t < 50);
        if (wb_ack_o !== 1'b1) begin
            n_mismatch++;
            $display("BAD t=%0t bus answer missing", $time);
        end
        r = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic cfg(input logic [6:0] c);
        @(posedge ref_clk);
        {asyncReadSel, asyncWriteSel, retransmitLatencySel, byteOrderSelect, fallThroughSelect,
         readPortWidthSel, writePortWidthSel} <= c;
        masterReset_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        masterReset_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        offsetDefaultSel <= 3'h0;
    endtask
    task automatic partial;
        partialReset_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        partialReset_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
    endtask
    task automatic summarize;
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #1_000_000;
        n_mismatch++;
        $display("BAD t=%0t watchdog expired", $time);
        summarize();
    end
    initial begin
        ref_clk = 1'b0;
        sys_rst = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        {masterReset_n, partialReset_n, outputEnable_n, flagTimingSel, offsetLoad_n, serialEnable_n} = 6'b110111;
        {asyncReadSel, asyncWriteSel, retransmitLatencySel, byteOrderSelect, fallThroughSelect} = '0;
        {readPortWidthSel, writePortWidthSel, serialIn} = '0;
        offsetDefaultSel = 3'h7;
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        cfg(7'h00);
        wbXfer(1'b0, 4'h0, 32'h0, q32);
        chk_word(q32, 32'h0000_1F1F);
        wbXfer(1'b1, 4'h0, 32'h0000_0503, q32);
        wbXfer(1'b0, 4'h0, 32'h0, q32);
        chk_word(q32, 32'h0000_0503);
        offsetLoad_n <= 1'b0;
        pm.push(18'h0_0006);
        pm.push(18'h0_0009);
        offsetLoad_n <= 1'b1;
        wbXfer(1'b0, 4'h0, 32'h0, q32);
        chk_word(q32, 32'h0000_0906);
        wbXfer(1'b0, 4'hC, 32'h0, q32);
        chk_word(q32, 32'h0);
        $display("test offsets finished");
        for (int i = 0; i < 8; i++) begin
            cfg({3'b001, i[2], 1'b0, i[1:0]});
            wbXfer(1'b0, 4'h8, 32'h0, q32);
            chk_word(q32 & 32'h0000_003F, {26'h0, i[2], 3'b000, i[1:0]});
            f = i[2] ? V[17:9] : V[8:0];
            s = i[2] ? V[8:0] : V[17:9];
            prev = readDataBus;
            if (i[0]) begin
                pm.push({9'h000, f});
                pm.push({9'h000, s});
            end else begin
                pm.push(V);
            end
            chk_word({14'h0, readDataBus}, {14'h0, prev});
            chk_flag(emptyFlag, 1'b0);
            pm.pop(q);
            chk_word({14'h0, q}, i[1] ? {23'h0, f} : {14'h0, V});
            if (i[1]) begin
                pm.pop(q);
                chk_word({14'h0, q}, {23'h0, s});
            end
            chk_flag(emptyFlag, 1'b1);
            prev = q;
            pm.pop(q);
            chk_word({14'h0, q}, {14'h0, prev});
        end
        $display("test widths finished");
        cfg(7'h10);
        for (int k = 0; k < 32; k++) pm.push(18'h0_0100 + 18'(k));
        chk_flag(fullFlag, 1'b1);
        chk_flag(halfFullFlag, 1'b1);
        chk_flag(almostFullFlag, 1'b1);
        chk_flag(almostEmptyFlag, 1'b0);
        wbXfer(1'b0, 4'h4, 32'h0, q32);
        chk_word(q32 & 32'h0000_017F, 32'h0000_0140);
        pm.push(18'h3_FFFF);
        for (int k = 0; k < 32; k++) begin
            pm.pop(q);
            chk_word({14'h0, q}, 32'h0000_0100 + 32'(k));
        end
        chk_flag(emptyFlag, 1'b1);
        chk_flag(almostEmptyFlag, 1'b1);
        chk_flag(almostFullFlag, 1'b0);
        $display("test full finished");
        cfg(7'h00);
        pm.push(V);
        pm.push(W);
        pm.pop(q);
        pm.pop(q);
        pm.tick(1, 1'b0);
        chk_word({14'h0, readDataBus}, {14'h0, V});
        pm.tick(1, 1'b1);
        pm.pop(q);
        chk_word({14'h0, q}, {14'h0, W});
        pm.push(V);
        partial();
        chk_flag(emptyFlag, 1'b1);
        chk_word({14'h0, readDataBus}, 32'h0);
        wbXfer(1'b0, 4'h8, 32'h0, q32);
        chk_flag(q32[6], 1'b1);
        $display("test retransmit finished");
        cfg(7'h14);
        chk_flag(inputRoomFlag, 1'b1);
        chk_flag(emptyFlag, 1'b0);
        pm.push(W);
        pm.tick(3, 1'b1);
        chk_word({14'h0, readDataBus}, {14'h0, W});
        chk_flag(outputValidFlag, 1'b1);
        pm.tick(1, 1'b1);
        partial();
        chk_flag(outputValidFlag, 1'b0);
        chk_flag(inputRoomFlag, 1'b1);
        $display("test fall-through finished");
        cfg(7'h70);
        pm.push(V);
        pm.push(W);
        pm.pop(q);
        chk_word({14'h0, q}, {14'h0, V});
        pm.pop(q);
        chk_word({14'h0, q}, {14'h0, W});
        $display("test strobes finished");
        outputEnable_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk_flag(readDataOe, 1'b0);
        outputEnable_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        chk_flag(readDataOe, 1'b1);
        $display("test output enable finished");
        summarize();
    end
endmodule
